//--- hdl/nid_defs.svh
// Constants for the instruction decoder: offsets, codes, timing figures.
// Assumes inclusion by bare name from the design files.
`ifndef NID_DEFS_SVH
`define NID_DEFS_SVH

`define NID_CLK_MHZ      125
`define NID_BYTE_TO_US   80
`define NID_EE_STORE_US  120
`define NID_PROT_ERA_US  100
`define NID_ERA_WIN_US   100
`define NID_PWRUP_MS     5

`define NID_UNL1_ADDR    12'h555
`define NID_UNL2_ADDR    12'hAAA
`define NID_CMD_UNL1     8'hAA
`define NID_CMD_UNL2     8'h55
`define NID_CMD_READ_ID  8'h90
`define NID_CMD_PROG     8'hA0
`define NID_CMD_ERASE    8'h80
`define NID_CMD_RESET    8'hF0
`define NID_CMD_CHIP     8'h10
`define NID_CMD_SECTOR   8'h30
`define NID_CMD_SDP_OFF  8'h20
`define NID_CMD_SUSPEND  8'hB0
`define NID_CMD_RESUME   8'h30
`define NID_CMD_PDOWN    8'h30

// Arbitrary identifier value
`define NID_FLASH_ID     8'h5A

`define NID_REG_CTRL     8'h00
`define NID_REG_PROT     8'h04
`define NID_REG_STATUS   8'h08
`define NID_REG_ID       8'h0C
`define NID_PROT_RST     8'h00
`define NID_CTRL_APD     0
`define NID_CTRL_FRESET  1

`define NID_RESP_OKAY    2'b00
`define NID_RESP_SLVERR  2'b10

`endif

//--- hdl/nid_pkg.sv
// Types shared by the instruction decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
package nid_pkg;

  typedef enum logic [7:0] {
    NID_ST_IDLE   = 8'h01,
    NID_ST_UNL1   = 8'h02,
    NID_ST_UNL2   = 8'h04,
    NID_ST_PROG   = 8'h08,
    NID_ST_ERA1   = 8'h10,
    NID_ST_ERA2   = 8'h20,
    NID_ST_ERA3   = 8'h40,
    NID_ST_IDREAD = 8'h80
  } nid_state_e;

  typedef logic [19:0] nid_cnt_t;

endpackage

//--- hdl/nid_tmr_if.sv
// Start, stop and status of one interval timer.
// Assumes the timer and its user share one clock.
`timescale 1ns/10ps
interface nid_tmr_if;
  logic start;
  logic stop;
  logic running;
  logic done;
  modport ctl (output start, output stop, input running, input done);
  modport tmr (input start, input stop, output running, output done);
endinterface

//--- hdl/nid_timer.sv
// One-shot interval timer: start reloads, stop clears, done pulses once.
// Assumes synchronous start/stop pulses on clk.
`timescale 1ns/10ps
module nid_timer #(
  parameter nid_pkg::nid_cnt_t LIMIT = 20'h00001
) (
  input  wire logic clk,
  input  wire logic rst_n,
  nid_tmr_if.tmr    t
);
  import nid_pkg::*;

  nid_cnt_t count;
  logic     expire;

  assign expire    = (count == 20'h00001);
  assign t.running = (count != 20'h00000);
  assign t.done    = expire & ~t.start & ~t.stop;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 20'h00000;
    end else if (t.start) begin
      count <= LIMIT;
    end else if (t.stop) begin
      count <= 20'h00000;
    end else if (t.running) begin
      count <= count - 20'h00001;
    end
  end
endmodule

//--- hdl/nid_decoder.sv
// Instruction decoder and status generator for flash and EEPROM regions.
// Assumes the host bus pins are asynchronous and held for several clocks.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "nid_defs.svh"
module nid_decoder #(
  parameter nid_pkg::nid_cnt_t BYTE_TO_CYC =
    nid_pkg::nid_cnt_t'(`NID_BYTE_TO_US * `NID_CLK_MHZ),
  parameter nid_pkg::nid_cnt_t EE_STORE_CYC =
    nid_pkg::nid_cnt_t'(`NID_EE_STORE_US * `NID_CLK_MHZ),
  parameter nid_pkg::nid_cnt_t PROT_ERA_CYC =
    nid_pkg::nid_cnt_t'(`NID_PROT_ERA_US * `NID_CLK_MHZ),
  parameter nid_pkg::nid_cnt_t ERA_WIN_CYC =
    nid_pkg::nid_cnt_t'(`NID_ERA_WIN_US * `NID_CLK_MHZ),
  parameter nid_pkg::nid_cnt_t PWRUP_CYC =
    nid_pkg::nid_cnt_t'(`NID_PWRUP_MS * 1000 * `NID_CLK_MHZ)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_data_in,
  output logic      [7:0]  bus_data_out,
  output logic             bus_data_oe_n,
  input  wire logic [7:0]  flash_sector_select,
  input  wire logic [3:0]  eeprom_sector_select,
  input  wire logic        auto_power_down_trigger,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        flash_busy,
  input  wire logic        flash_erasing,
  input  wire logic        flash_error,
  input  wire logic        ee_busy,
  output logic             ee_wr_pulse,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data,
  output logic             flash_prog_pulse,
  output logic             flash_erase_pulse,
  output logic             flash_chip_erase,
  output logic      [7:0]  erase_sector_mask,
  output logic             erase_suspend_pulse,
  output logic             erase_resume_pulse,
  output logic             sdp_disable_pulse,
  output logic             ee_store_start,
  output logic             ee_powered_down,
  output logic             otp_select,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import nid_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [26:0] pin_s1;
  logic [26:0] pin_s2;
  logic        wr_d;
  logic        rd_d;
  nid_state_e  state;
  nid_state_e  next_state;
  logic        seq_ee;
  logic        next_seq_ee;
  logic        ee_down;
  logic        otp_mode;
  logic        ee_pending;
  logic        toggle;
  logic        prog_bit7;
  logic        ee_bit7;
  logic [7:0]  prot;
  logic        apd_sw;
  logic        freset_sw;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  nid_tmr_if t_byte ();
  nid_tmr_if t_store ();
  nid_tmr_if t_prot ();
  nid_tmr_if t_win ();
  nid_tmr_if t_pwr ();

  nid_timer #(.LIMIT(BYTE_TO_CYC))  u_byte  (.clk(clk), .rst_n(rst_n),
                                             .t(t_byte));
  nid_timer #(.LIMIT(EE_STORE_CYC)) u_store (.clk(clk), .rst_n(rst_n),
                                             .t(t_store));
  nid_timer #(.LIMIT(PROT_ERA_CYC)) u_prot  (.clk(clk), .rst_n(rst_n),
                                             .t(t_prot));
  nid_timer #(.LIMIT(ERA_WIN_CYC))  u_win   (.clk(clk), .rst_n(rst_n),
                                             .t(t_win));
  nid_timer #(.LIMIT(PWRUP_CYC))    u_pwr   (.clk(clk), .rst_n(rst_n),
                                             .t(t_pwr));

  // Reset release and pin synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 27'h0000000;
      pin_s2 <= 27'h0000000;
      wr_d   <= 1'b0;
      rd_d   <= 1'b0;
    end else begin
      pin_s1 <= {bus_wr, bus_rd, bus_addr[11:0], bus_data_in,
                 |flash_sector_select, |eeprom_sector_select,
                 bus_addr[6], bus_addr[1], bus_addr[0]};
      pin_s2 <= pin_s1;
      wr_d   <= pin_s2[26];
      rd_d   <= pin_s2[25];
    end
  end

  // Decoded bus fields; bits 15..12 never enter the decoder
  logic [11:0] a12;
  logic [7:0]  din;
  logic        fl_sel;
  logic        ee_sel;
  logic [2:0]  a_sel;
  logic [7:0]  fsel_s;
  logic        wr_ev;
  logic        rd_ev;
  logic        ee_gate;
  logic        wr_go;
  logic        is_u1;
  logic        is_u2;
  logic        at555;
  logic        fsel_prot;
  logic [7:0]  era_mask;
  assign a12      = pin_s2[24:13];
  assign din      = pin_s2[12:5];
  assign fl_sel   = pin_s2[4];
  assign ee_sel   = pin_s2[3];
  assign a_sel    = pin_s2[2:0];
  assign wr_ev    = pin_s2[26] & ~wr_d;
  assign rd_ev    = pin_s2[25] & ~rd_d;
  assign is_u1    = (din == `NID_CMD_UNL1) && (a12 == `NID_UNL1_ADDR);
  assign is_u2    = (din == `NID_CMD_UNL2) && (a12 == `NID_UNL2_ADDR);
  assign at555    = (a12 == `NID_UNL1_ADDR);
  // Blocked EEPROM writes: power-up window or power-down except return
  assign ee_gate  = ee_sel & (t_pwr.running |
                    (ee_down & ~((din == `NID_CMD_RESET) &
                                 (state == NID_ST_IDLE))));
  assign wr_go    = wr_ev & ~ee_gate;
  assign fsel_prot = |(fsel_s & prot);
  assign era_mask = fsel_s & ~prot;

  // Sector select vector is sampled alongside the strobes
  logic [7:0] fsel_s1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsel_s1 <= 8'h00;
      fsel_s  <= 8'h00;
    end else begin
      fsel_s1 <= flash_sector_select;
      fsel_s  <= fsel_s1;
    end
  end

  logic ord_wr;
  logic do_prog;
  logic do_chip;
  logic do_sect;
  logic do_susp;
  logic do_res;
  logic do_sdp_off;
  logic do_ret;
  logic do_pdown;
  logic do_otp;
  logic byte_ok;
  logic abort;

  always_comb begin
    next_state  = state;
    next_seq_ee = seq_ee;
    ord_wr      = 1'b0;
    do_prog     = 1'b0;
    do_chip     = 1'b0;
    do_sect     = 1'b0;
    do_susp     = 1'b0;
    do_res      = 1'b0;
    do_sdp_off  = 1'b0;
    do_ret      = 1'b0;
    do_pdown    = 1'b0;
    do_otp      = 1'b0;
    byte_ok     = 1'b0;
    abort       = 1'b0;
    if (freset_sw) begin
      next_state = NID_ST_IDLE;
    end else if (t_byte.done && state != NID_ST_IDREAD) begin
      next_state = NID_ST_IDLE;
    end else if (wr_go) begin
      unique case (state)
        NID_ST_IDLE: begin
          if (is_u1) begin
            next_state  = NID_ST_UNL1;
            next_seq_ee = ee_sel;
            byte_ok     = 1'b1;
          end else if (din == `NID_CMD_RESET) begin
            do_ret = ee_sel;
          end else if (fl_sel && din == `NID_CMD_SUSPEND) begin
            do_susp = 1'b1;
          end else if (fl_sel && din == `NID_CMD_RESUME) begin
            do_res = 1'b1;
          end else begin
            ord_wr = ee_sel;
          end
        end
        NID_ST_UNL1: begin
          if (is_u2) begin
            next_state = NID_ST_UNL2;
            byte_ok    = 1'b1;
          end else begin
            abort = 1'b1;
          end
        end
        NID_ST_UNL2: begin
          next_state = NID_ST_IDLE;
          if (din == `NID_CMD_RESET) begin
            do_ret = seq_ee;
          end else if (!at555) begin
            abort = 1'b1;
          end else if (din == `NID_CMD_READ_ID) begin
            do_otp = seq_ee;
            next_state = seq_ee ? NID_ST_IDLE : NID_ST_IDREAD;
          end else if (din == `NID_CMD_PROG) begin
            next_state = NID_ST_PROG;
            byte_ok    = 1'b1;
          end else if (din == `NID_CMD_ERASE) begin
            next_state = NID_ST_ERA1;
            byte_ok    = 1'b1;
          end else if (seq_ee && din == `NID_CMD_PDOWN) begin
            do_pdown = 1'b1;
          end else begin
            abort = 1'b1;
          end
        end
        NID_ST_PROG: begin
          if (seq_ee) begin
            ord_wr  = 1'b1;
            byte_ok = 1'b1;
          end else begin
            do_prog    = ~fsel_prot;
            next_state = NID_ST_IDLE;
          end
        end
        NID_ST_ERA1: begin
          next_state = is_u1 ? NID_ST_ERA2 : NID_ST_IDLE;
          byte_ok    = is_u1;
          abort      = ~is_u1;
        end
        NID_ST_ERA2: begin
          next_state = is_u2 ? NID_ST_ERA3 : NID_ST_IDLE;
          byte_ok    = is_u2;
          abort      = ~is_u2;
        end
        NID_ST_ERA3: begin
          if (!seq_ee && din == `NID_CMD_SECTOR) begin
            do_sect = 1'b1;
            byte_ok = 1'b1;
          end else if (!seq_ee && at555 && din == `NID_CMD_CHIP &&
                       !t_win.running) begin
            do_chip    = 1'b1;
            next_state = NID_ST_IDLE;
          end else if (seq_ee && at555 && din == `NID_CMD_SDP_OFF) begin
            do_sdp_off = 1'b1;
            next_state = NID_ST_IDLE;
          end else begin
            abort = 1'b1;
          end
        end
        NID_ST_IDREAD: begin
          if (din == `NID_CMD_RESET) begin
            next_state = NID_ST_IDLE;
          end else if (is_u1) begin
            next_state  = NID_ST_UNL1;
            next_seq_ee = ee_sel;
            byte_ok     = 1'b1;
          end
        end
      endcase
      if (abort) begin
        next_state = NID_ST_IDLE;
        ord_wr     = ee_sel;
      end
    end
  end

  assign t_byte.start  = byte_ok;
  assign t_byte.stop   = wr_go & ~byte_ok;
  assign t_store.start = ord_wr;
  assign t_store.stop  = 1'b0;
  assign t_prot.start  = do_sect & (era_mask == 8'h00);
  assign t_prot.stop   = 1'b0;
  assign t_win.start   = do_sect;
  assign t_win.stop    = do_chip;
  assign t_pwr.stop    = 1'b0;

  // Instruction state and command strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= NID_ST_IDLE;
      seq_ee <= 1'b0;
    end else begin
      state  <= next_state;
      seq_ee <= next_seq_ee;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_wr_pulse         <= 1'b0;
      flash_prog_pulse    <= 1'b0;
      flash_erase_pulse   <= 1'b0;
      flash_chip_erase    <= 1'b0;
      erase_suspend_pulse <= 1'b0;
      erase_resume_pulse  <= 1'b0;
      sdp_disable_pulse   <= 1'b0;
      ee_store_start      <= 1'b0;
      wr_addr             <= 16'h0000;
      wr_data             <= 8'h00;
      erase_sector_mask   <= 8'h00;
    end else begin
      ee_wr_pulse         <= ord_wr;
      flash_prog_pulse    <= do_prog;
      flash_erase_pulse   <= do_chip | (do_sect & (era_mask != 8'h00));
      flash_chip_erase    <= do_chip;
      erase_suspend_pulse <= do_susp;
      erase_resume_pulse  <= do_res;
      sdp_disable_pulse   <= do_sdp_off;
      ee_store_start      <= t_store.done;
      if (wr_go) begin
        wr_addr <= {4'h0, a12};
        wr_data <= din;
      end
      if (do_chip) begin
        erase_sector_mask <= 8'hFF;
      end else if (do_sect) begin
        erase_sector_mask <= era_mask;
      end
    end
  end

  // EEPROM power-down, one-time row mode, pending store, polled bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_down    <= 1'b0;
      otp_mode   <= 1'b0;
      ee_pending <= 1'b0;
      prog_bit7  <= 1'b0;
      ee_bit7    <= 1'b0;
    end else begin
      if (do_pdown || auto_power_down_trigger || apd_sw) begin
        ee_down <= 1'b1;
      end else if (do_ret) begin
        ee_down <= 1'b0;
      end
      if (do_otp) begin
        otp_mode <= 1'b1;
      end else if (do_ret) begin
        otp_mode <= 1'b0;
      end
      if (ord_wr) begin
        ee_pending <= 1'b1;
        ee_bit7    <= din[7];
      end else if (t_store.done) begin
        ee_pending <= 1'b0;
      end
      if (do_prog) begin
        prog_bit7 <= din[7];
      end
    end
  end

  // Read data: zero from powered-down EEPROM, status while busy, identifier reads, else memory
  logic       fl_busy_rd;
  logic       ee_busy_rd;
  logic       poll_status_bit;
  logic       erase_window_bit;
  logic [7:0] next_rdata;
  assign fl_busy_rd = fl_sel & (flash_busy | t_prot.running);
  assign ee_busy_rd = ee_sel & (ee_busy | ee_pending);
  assign poll_status_bit = (flash_erasing | t_prot.running) ? 1'b0 :
                           ~prog_bit7;
  assign erase_window_bit = ~t_win.running;
  assign next_rdata =
    (ee_sel & ee_down) ? 8'h00 :
    fl_busy_rd ? {poll_status_bit, toggle, flash_error, 1'b0,
                  erase_window_bit, 3'b000} :
    ee_busy_rd ? {~ee_bit7, toggle, 6'h00} :
    (fl_sel && state == NID_ST_IDREAD && a_sel == 3'b001) ?
      `NID_FLASH_ID :
    (fl_sel && state == NID_ST_IDREAD && a_sel == 3'b010) ?
      {7'h00, fsel_prot} :
    mem_rdata;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_out <= 8'h00;
      toggle       <= 1'b0;
    end else if (rd_ev) begin
      bus_data_out <= next_rdata;
      if (fl_busy_rd || ee_busy_rd) begin
        toggle <= ~toggle;
      end
    end
  end

  assign bus_data_oe_n   = ~(rd_d & (fl_sel | ee_sel));
  assign ee_powered_down = ee_down;
  assign otp_select      = otp_mode & ee_sel & ~a_sel[2];

  // AXI4-Lite register slave
  logic       wr_do;
  logic       wr_hit;
  logic       rd_do;
  logic       rd_hit;
  logic [31:0] rd_val;
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_do  = aw_got & w_got & ~s_axi_bvalid;
  assign wr_hit = (aw_addr == `NID_REG_CTRL) | (aw_addr == `NID_REG_PROT);
  assign rd_do  = s_axi_arvalid & s_axi_arready;
  assign rd_hit = (s_axi_araddr == `NID_REG_CTRL) |
                  (s_axi_araddr == `NID_REG_PROT) |
                  (s_axi_araddr == `NID_REG_STATUS) |
                  (s_axi_araddr == `NID_REG_ID);
  assign rd_val =
    (s_axi_araddr == `NID_REG_PROT) ? {24'h000000, prot} :
    (s_axi_araddr == `NID_REG_STATUS) ?
      {18'h00000, flash_busy, ee_busy, ee_pending, t_pwr.running,
       otp_mode, ee_down, state} :
    (s_axi_araddr == `NID_REG_ID) ? {24'h000000, `NID_FLASH_ID} :
    32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NID_RESP_OKAY;
      prot         <= `NID_PROT_RST;
      apd_sw       <= 1'b0;
      freset_sw    <= 1'b0;
    end else begin
      apd_sw    <= 1'b0;
      freset_sw <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `NID_RESP_OKAY : `NID_RESP_SLVERR;
        if (aw_addr == `NID_REG_PROT && w_strb[0]) begin
          prot <= w_data[7:0];
        end
        if (aw_addr == `NID_REG_CTRL && w_strb[0]) begin
          apd_sw    <= w_data[`NID_CTRL_APD];
          freset_sw <= w_data[`NID_CTRL_FRESET];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `NID_RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {s_axi_araddr[7:2], 2'b00} == `NID_REG_STATUS ?
                      rd_val : (rd_hit ? rd_val : 32'h00000000);
      s_axi_rresp  <= rd_hit ? `NID_RESP_OKAY : `NID_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Power-up write inhibit starts once at reset release
  logic pwr_armed;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_armed <= 1'b0;
    end else begin
      pwr_armed <= 1'b1;
    end
  end
  assign t_pwr.start = ~pwr_armed;
endmodule

//--- dv/nid_decoder_properties.sv
// Port checker for the instruction decoder.
// Assumes a bind onto nid_decoder.
`timescale 1ns/10ps
module nid_chk #(parameter int PWR = 50) (
  input wire logic clk, nrst, flash_prog_pulse, flash_erase_pulse,
  input wire logic flash_chip_erase, ee_wr_pulse, ee_store_start,
  input wire logic ee_powered_down, otp_select, bus_data_oe_n,
  input wire logic auto_power_down_trigger
);
  int cnt;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) cnt <= 0;
    else if (cnt < PWR) cnt <= cnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_chip; flash_chip_erase |-> flash_erase_pulse; endproperty
  a_chip: assert property (p_chip) else $error("chip erase");
  property p_prog; flash_prog_pulse |=> !flash_prog_pulse; endproperty
  a_prog: assert property (p_prog) else $error("prog pulse");
  property p_ee; ee_wr_pulse |=> !ee_wr_pulse; endproperty
  a_ee: assert property (p_ee) else $error("ee pulse");
  property p_apd; auto_power_down_trigger |-> ##[0:3] ee_powered_down;
  endproperty
  a_apd: assert property (p_apd) else $error("no power-down");
  property p_pd; ee_powered_down && $past(ee_powered_down) |-> !ee_wr_pulse;
  endproperty
  a_pd: assert property (p_pd) else $error("write when down");
  property p_rst; $rose(nrst) |-> bus_data_oe_n && !otp_select; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_pwr; cnt < PWR |-> !ee_wr_pulse; endproperty
  a_pwr: assert property (p_pwr) else $error("early write");
  property p_st; ee_wr_pulse |=> !ee_store_start [*8]; endproperty
  a_st: assert property (p_st) else $error("early store");
  c_prog: cover property (flash_prog_pulse);
  c_ee: cover property (ee_wr_pulse);
  c_apd: cover property (auto_power_down_trigger);
endmodule
bind nid_decoder nid_chk #(.PWR(PWRUP_CYC)) u_chk (.*);

//--- dv/nid_host.sv
// Host bus model: one strobed byte write or read per call.
// Assumes two-flop pin sampling in the decoder.
`timescale 1ns/10ps
module nid_host (
  input  wire logic        clk,
  input  wire logic [7:0]  bus_data_out,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_data_in,
  output logic [7:0]       flash_sector_select,
  output logic [3:0]       eeprom_sector_select
);
  logic [7:0] q;
  initial {bus_wr, bus_rd, bus_addr, bus_data_in} = 26'h0;
  initial {flash_sector_select, eeprom_sector_select} = 12'h000;
  task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                     input logic ee, input logic w);
    {bus_addr, bus_data_in} <= {a, d};
    {flash_sector_select, eeprom_sector_select} <=
      ee ? 12'h001 : 12'h010;
    repeat (3) @(posedge clk);
    {bus_wr, bus_rd} <= {w, !w};
    repeat (6) @(posedge clk);
    q = bus_data_out;
    {bus_wr, bus_rd} <= 2'b00;
    repeat (4) @(posedge clk);
    {flash_sector_select, eeprom_sector_select} <= 12'h000;
    bus_data_in <= ~d;
    @(posedge clk);
  endtask
endmodule

//--- dv/nvm_instruction_decoder_status_tb.sv
// Bench: host bus model, register bus master, engine inputs.
// Assumes the checker and host model compile first.
`timescale 1ns/10ps
module nvm_instruction_decoder_status_tb;
  logic clk, nrst, bus_wr, bus_rd, bus_data_oe_n, flash_busy, flash_erasing;
  logic flash_error, ee_busy, ee_wr_pulse, flash_prog_pulse, otp_select;
  logic flash_erase_pulse, flash_chip_erase, erase_suspend_pulse;
  logic erase_resume_pulse, sdp_disable_pulse, ee_store_start;
  logic ee_powered_down, auto_power_down_trigger, s_axi_awvalid;
  logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] eeprom_sector_select, s_axi_wstrb;
  logic [7:0] bus_data_in, bus_data_out, flash_sector_select, mem_rdata, ld;
  logic [7:0] wr_data, erase_sector_mask, s_axi_awaddr, s_axi_araddr;
  logic [15:0] bus_addr, wr_addr, la;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int num_errors, comparisons, np, ne;
  assign mem_rdata = bus_addr[7:0] ^ 8'hC3;
  nid_decoder #(.BYTE_TO_CYC(40), .EE_STORE_CYC(30), .PROT_ERA_CYC(30),
    .ERA_WIN_CYC(30), .PWRUP_CYC(50)) uut (.*);
  nid_host u_host (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (flash_prog_pulse) begin
      np++;
      {la, ld} <= {wr_addr, wr_data};
    end
    if (ee_wr_pulse) ne++;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task hw(input logic [15:0] a, input logic [7:0] v, input logic ee);
    u_host.cyc(a, v, ee, 1'b1);
  endtask
  task hr(input logic [15:0] a);
    u_host.cyc(a, 8'h00, 1'b0, 1'b0);
  endtask
  task unl(input logic [7:0] c, input logic ee, input int gap);
    hw(16'hF555, 8'hAA, ee);
    hw(16'h3AAA, 8'h55, ee);
    repeat (gap) @(posedge clk);
    hw(16'h0555, c, ee);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'b11};
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task axr(input logic [7:0] a);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask
  task t_ee;
    hw(16'h0100, 8'h11, 1'b1);
    chk("inhibit", ne, 0);
    repeat (40) @(posedge clk);
    hw(16'hF555, 8'hAA, 1'b1);
    hw(16'h0100, 8'h12, 1'b1);
    chk("stray byte", ne, 1);
  endtask
  task t_id;
    unl(8'h90, 1'b0, 0);
    hr(16'h0001);
    chk("id", u_host.q, 8'h5A);
    hr(16'h0002);
    chk("unprot", u_host.q, 8'h00);
    axw(8'h04, 32'h1);
    hr(16'h0002);
    chk("prot", u_host.q, 8'h01);
    hw(16'h0000, 8'hF0, 1'b0);
    hr(16'h0123);
    chk("read", u_host.q, 8'hE0);
    axr(8'h0C);
    chk("id reg", d, 32'h5A);
    axr(8'h10);
    chk("unmapped", r, 2'b10);
  endtask
  task t_prog;
    unl(8'hA0, 1'b0, 0);
    hw(16'h0123, 8'h3C, 1'b0);
    chk("protected", np, 0);
    axw(8'h04, 32'h0);
    unl(8'hA0, 1'b0, 0);
    hw(16'hF123, 8'h3C, 1'b0);
    chk("prog", np, 1);
    chk("target", {la, ld}, 24'h01233C);
    flash_busy <= 1'b1;
    hr(16'h0123);
    chk("poll", u_host.q, 8'h88);
    hr(16'h0123);
    chk("toggle", u_host.q, 8'hC8);
    flash_busy <= 1'b0;
    unl(8'h80, 1'b0, 0);
    unl(8'h10, 1'b0, 0);
    chk("chip", erase_sector_mask, 8'hFF);
    unl(8'h80, 1'b0, 0);
    unl(8'h30, 1'b0, 0);
    hw(16'h1000, 8'h30, 1'b0);
    chk("sector", erase_sector_mask, 8'h01);
  endtask
  task t_bad;
    unl(8'h12, 1'b0, 0);
    hw(16'h0200, 8'h77, 1'b0);
    chk("bad byte", np, 1);
    unl(8'hA0, 1'b0, 50);
    hw(16'h0200, 8'h77, 1'b0);
    chk("timeout", np, 1);
  endtask
  task t_pd;
    unl(8'h30, 1'b1, 0);
    hw(16'h0100, 8'h33, 1'b1);
    chk("blocked", ne, 1);
    chk("down", ee_powered_down, 1);
    hw(16'h0000, 8'hF0, 1'b1);
    chk("up", ee_powered_down, 0);
    hw(16'h0100, 8'h44, 1'b1);
    chk("ee write", ne, 2);
    u_host.cyc(16'h0100, 8'h00, 1'b1, 1'b0);
    chk("ee poll", u_host.q, 8'h80);
    auto_power_down_trigger <= 1'b1;
    @(posedge clk) auto_power_down_trigger <= 1'b0;
    repeat (4) @(posedge clk);
    chk("auto", ee_powered_down, 1);
  endtask
  initial begin
    {nrst, flash_busy, flash_erasing, flash_error, ee_busy} = 5'h0;
    {auto_power_down_trigger, s_axi_awvalid, s_axi_wvalid} = 3'b000;
    {s_axi_arvalid, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_ee;
    t_id;
    t_prog;
    t_bad;
    t_pd;
    final_report;
  end
  initial begin
    #50000;
    num_errors++;
    final_report;
  end
endmodule
